// ### hdl/laser_driver_control_registers.sv
// Notes on behaviour
// - only addresses zero to three select a register.
// - control register bits 7..1: enable, polarity, range, open loop, fault, mod range, bypass.
// - address one holds the 8-bit modulation current code.
// - address two holds the 8-bit bias current code.
// - address three holds the 8-bit equalizer adjustment code.
// - chip is enabled only while the enable bit is one.
// - enable written low then high clears a latched fault.
// - polarity one ties cathode to supply, zero ties anode to ground.
// - range one gives 2.5 ua steps, zero gives 0.5 ua steps.
// - open loop select one gives open loop, zero closed loop bias control.
// - fault detect enable one turns fault detection on.
// - modulation range one gives 0-40 ma, zero gives 0-20 ma.
// - bypass one bypasses the equalizer, zero enables it.
// - high modulation range: each code unit is a 156 ua step.
// - low modulation range: each code unit is a 78 ua step.
// - modulation code is unsigned, bit 7 most significant.
// - on a stop after eleven bits the shifted data goes to the addressed register.
// - reset clears every configuration register to zero.
// - enabled equalizer: all zeros strongest, all ones weakest equalization.
module laser_driver_control_registers (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic sda,
   input wire logic sck,
   output logic chipEnableBit,
   output logic photodiodePolarityBit,
   output logic photodiodeRangeBit,
   output logic openLoopSelectBit,
   output logic faultDetectEnableBit,
   output logic modulationRangeBit,
   output logic equalizerBypassBit,
   output logic [7:0] modulationCurrentCode,
   output logic [7:0] biasCurrentCode,
   output logic [7:0] equalizerAdjustCode,
   output logic faultClear,
   output logic [15:0] modCurrentUa,
   output logic [4:0] pdStepTenthUa,
   output logic [7:0] equalizerStrength
);

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------

   logic sdaSync;
   logic sdaPrev;
   logic sckSync;
   logic sckPrev;

   pin_sync sdaSyncInst (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pinIn(sda),
      .pinSync(sdaSync),
      .pinPrev(sdaPrev)
   );

   pin_sync sckSyncInst (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pinIn(sck),
      .pinSync(sckSync),
      .pinPrev(sckPrev)
   );

   // ----------------------------------------
   // line conditions
   // ----------------------------------------

   logic startSeen;
   logic stopSeen;
   logic sckRise;

   // start is sda falling with the clock high, stop is sda rising
   assign startSeen = sckSync && sckPrev && sdaPrev && !sdaSync;
   assign stopSeen = sckSync && sckPrev && !sdaPrev && sdaSync;
   assign sckRise = sckSync && !sckPrev;

   // ----------------------------------------
   // frame decoder
   // ----------------------------------------

   laser_cfg_pkg::frame_state_t state_q;
   laser_cfg_pkg::frame_state_t state_d;
   logic [10:0] shift_q;
   logic [3:0] bitCount_q;
   logic wrEn;
   logic [2:0] wrAddr;
   logic [7:0] wrData;

   // next frame state
   always_comb begin
      state_d = state_q;
      case (state_q)
         laser_cfg_pkg::FRAME_IDLE: begin
            if (startSeen) begin
               state_d = laser_cfg_pkg::FRAME_SHIFT;
            end
         end
         laser_cfg_pkg::FRAME_SHIFT: begin
            if (stopSeen) begin
               state_d = laser_cfg_pkg::FRAME_IDLE;
            end
         end
         default: begin
            state_d = laser_cfg_pkg::FRAME_IDLE;
         end
      endcase
   end

   // frame state register
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_q <= laser_cfg_pkg::FRAME_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // shift register, first eleven clock rises only, msb first
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         shift_q <= 11'h000;
      end else if (state_q == laser_cfg_pkg::FRAME_SHIFT && sckRise
                   && bitCount_q < laser_cfg_pkg::FRAME_BIT_COUNT) begin
         shift_q <= {shift_q[9:0], sdaSync};
      end
   end

   // bit counter, restarted by every start, saturating
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         bitCount_q <= 4'h0;
      end else if (startSeen) begin
         bitCount_q <= 4'h0;
      end else if (state_q == laser_cfg_pkg::FRAME_SHIFT && sckRise
                   && bitCount_q != laser_cfg_pkg::BIT_COUNT_MAX) begin
         bitCount_q <= bitCount_q + 4'h1;
      end
   end

   // copy on a stop after eleven bits; the stop's own clock rise is the twelfth
   assign wrEn = (state_q == laser_cfg_pkg::FRAME_SHIFT) && stopSeen
      && (bitCount_q == laser_cfg_pkg::FRAME_BIT_COUNT + 4'h1);
   assign wrAddr = shift_q[10:8];
   assign wrData = shift_q[7:0];

   // ----------------------------------------
   // register bank
   // ----------------------------------------

   logic [7:0] controlFlags;

   config_regs regsInst (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .wrEn(wrEn),
      .wrAddr(wrAddr),
      .wrData(wrData),
      .controlFlags(controlFlags),
      .modulationCurrentCode(modulationCurrentCode),
      .biasCurrentCode(biasCurrentCode),
      .equalizerAdjustCode(equalizerAdjustCode)
   );

   // control fields to their own pins
   assign chipEnableBit = controlFlags[laser_cfg_pkg::BIT_CHIP_ENABLE];
   assign photodiodePolarityBit = controlFlags[laser_cfg_pkg::BIT_PD_POLARITY];
   assign photodiodeRangeBit = controlFlags[laser_cfg_pkg::BIT_PD_RANGE];
   assign openLoopSelectBit = controlFlags[laser_cfg_pkg::BIT_OPEN_LOOP];
   assign faultDetectEnableBit = controlFlags[laser_cfg_pkg::BIT_FAULT_DETECT];
   assign modulationRangeBit = controlFlags[laser_cfg_pkg::BIT_MOD_RANGE];
   assign equalizerBypassBit = controlFlags[laser_cfg_pkg::BIT_EQ_BYPASS];

   // ----------------------------------------
   // fault recovery
   // ----------------------------------------

   logic enablePrev_q;

   // remembers the enable level of the previous cycle
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         enablePrev_q <= 1'b0;
      end else begin
         enablePrev_q <= chipEnableBit;
      end
   end

   // one pulse when enable returns high after being low
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         faultClear <= 1'b0;
      end else begin
         faultClear <= chipEnableBit && !enablePrev_q;
      end
   end

   // ----------------------------------------
   // derived analog settings
   // ----------------------------------------

   // modulation current as unsigned code times range step
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         modCurrentUa <= laser_cfg_pkg::RESET_CURRENT;
      end else if (modulationRangeBit) begin
         modCurrentUa <= 16'({8'h00, modulationCurrentCode}
            * laser_cfg_pkg::MOD_STEP_HIGH_UA);
      end else begin
         modCurrentUa <= 16'({8'h00, modulationCurrentCode}
            * laser_cfg_pkg::MOD_STEP_LOW_UA);
      end
   end

   // photodiode resolution in tenths of a microamp
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pdStepTenthUa <= laser_cfg_pkg::PD_STEP_LOW_TENTH_UA;
      end else if (photodiodeRangeBit) begin
         pdStepTenthUa <= laser_cfg_pkg::PD_STEP_HIGH_TENTH_UA;
      end else begin
         pdStepTenthUa <= laser_cfg_pkg::PD_STEP_LOW_TENTH_UA;
      end
   end

   // equalization grows as the code falls, none when bypassed
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         equalizerStrength <= laser_cfg_pkg::EQ_STRENGTH_OFF;
      end else if (equalizerBypassBit) begin
         equalizerStrength <= laser_cfg_pkg::EQ_STRENGTH_OFF;
      end else begin
         equalizerStrength <= ~equalizerAdjustCode;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------

   sequence startSeq;
      sckSync && sckPrev && sdaPrev && !sdaSync;
   endsequence

   sequence elevenBitsSeq;
      (state_q == laser_cfg_pkg::FRAME_SHIFT) && (bitCount_q == 4'hC);
   endsequence

   sequence stopSeq;
      sckSync && sckPrev && !sdaPrev && sdaSync;
   endsequence

   a_start_enters_shift: assert property (@(posedge clk_sys) disable iff (!rst_n)
      startSeq |=> (state_q == laser_cfg_pkg::FRAME_SHIFT) && (bitCount_q == 4'h0))
      else $error("start did not open a frame");

   a_stop_writes_reg: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (elevenBitsSeq and stopSeq) ##0 (shift_q[10:8] == 3'h1)
         |=> modulationCurrentCode == $past(shift_q[7:0]))
      else $error("stop did not load modulation code");

   a_ctrl_bit0_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (elevenBitsSeq and stopSeq) ##0 (shift_q[10:8] == 3'h0)
         |=> (controlFlags == ($past(shift_q[7:0]) & 8'hFE)) && !controlFlags[0])
      else $error("control register load wrong or bit 0 stored");

   a_short_frame_drop: assert property (@(posedge clk_sys) disable iff (!rst_n)
      stopSeq and (bitCount_q != 4'hC) |=> $stable(controlFlags)
         && $stable(biasCurrentCode))
      else $error("incomplete frame changed a register");

   a_fault_clear_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(chipEnableBit) |=> faultClear ##1 !faultClear)
      else $error("enable toggle gave no single clear pulse");

   a_fault_clear_cause: assert property (@(posedge clk_sys) disable iff (!rst_n)
      faultClear |-> $past(chipEnableBit) && !$past(enablePrev_q))
      else $error("fault clear without enable rising");

   a_mod_current_val: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $stable(modulationCurrentCode) && $stable(modulationRangeBit) |=>
         modCurrentUa == ($past(modulationRangeBit)
            ? 16'(($past(modulationCurrentCode)) * 156)
            : 16'(($past(modulationCurrentCode)) * 78)))
      else $error("modulation current does not match code and range");

   a_pd_step_val: assert property (@(posedge clk_sys) disable iff (!rst_n)
      photodiodeRangeBit [*2] |-> pdStepTenthUa == 5'h19)
      else $error("photodiode high range step wrong");

   a_eq_strength_val: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !equalizerBypassBit ##1 !equalizerBypassBit && $stable(equalizerAdjustCode)
         |-> equalizerStrength == 8'hFF - equalizerAdjustCode)
      else $error("equalizer strength not inverse of code");

   a_eq_bypass_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
      equalizerBypassBit |=> equalizerStrength == 8'h00)
      else $error("bypassed equalizer still active");

endmodule

// ### hdl/laser_cfg_pkg.sv
package laser_cfg_pkg;

   // ----------------------------------------
   // serial frame layout
   // ----------------------------------------
   localparam int ADDR_BITS = 3;
   localparam int DATA_BITS = 8;
   localparam int FRAME_BITS = ADDR_BITS + DATA_BITS;
   localparam logic [3:0] FRAME_BIT_COUNT = 4'hB;
   localparam logic [3:0] BIT_COUNT_MAX = 4'hF;

   // ----------------------------------------
   // register addresses
   // ----------------------------------------
   localparam logic [2:0] ADDR_CONTROL_FLAGS = 3'h0;
   localparam logic [2:0] ADDR_MODULATION_CODE = 3'h1;
   localparam logic [2:0] ADDR_BIAS_CODE = 3'h2;
   localparam logic [2:0] ADDR_EQUALIZER_CODE = 3'h3;

   // ----------------------------------------
   // control flag bit positions
   // ----------------------------------------
   localparam int BIT_CHIP_ENABLE = 7;
   localparam int BIT_PD_POLARITY = 6;
   localparam int BIT_PD_RANGE = 5;
   localparam int BIT_OPEN_LOOP = 4;
   localparam int BIT_FAULT_DETECT = 3;
   localparam int BIT_MOD_RANGE = 2;
   localparam int BIT_EQ_BYPASS = 1;
   localparam logic [7:0] CONTROL_WRITE_MASK = 8'hFE;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [7:0] RESET_REG = 8'h00;
   localparam logic [15:0] RESET_CURRENT = 16'h0000;

   // ----------------------------------------
   // analog step sizes
   // ----------------------------------------
   localparam logic [15:0] MOD_STEP_HIGH_UA = 16'h009C; // 156 ua per code
   localparam logic [15:0] MOD_STEP_LOW_UA = 16'h004E; // 78 ua per code
   localparam logic [4:0] PD_STEP_HIGH_TENTH_UA = 5'h19; // 2.5 ua
   localparam logic [4:0] PD_STEP_LOW_TENTH_UA = 5'h05; // 0.5 ua
   localparam logic [7:0] EQ_STRENGTH_OFF = 8'h00;

   // ----------------------------------------
   // frame decoder states
   // ----------------------------------------
   typedef enum logic [0:0] {
      FRAME_IDLE = 1'b0,
      FRAME_SHIFT = 1'b1
   } frame_state_t;

endpackage

// ### hdl/pin_sync.sv
module pin_sync (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic pinIn,
   output logic pinSync,
   output logic pinPrev
);

   logic meta_q;

   // two-flop synchroniser, third flop for edge detection
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         meta_q <= 1'b1;
         pinSync <= 1'b1;
         pinPrev <= 1'b1;
      end else begin
         meta_q <= pinIn;
         pinSync <= meta_q;
         pinPrev <= pinSync;
      end
   end

endmodule

// ### hdl/config_regs.sv
module config_regs (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic wrEn,
   input wire logic [2:0] wrAddr,
   input wire logic [7:0] wrData,
   output logic [7:0] controlFlags,
   output logic [7:0] modulationCurrentCode,
   output logic [7:0] biasCurrentCode,
   output logic [7:0] equalizerAdjustCode
);

   // ----------------------------------------
   // register bank
   // ----------------------------------------

   // decode of the three address bits, writes beyond 3 dropped
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         controlFlags <= laser_cfg_pkg::RESET_REG;
         modulationCurrentCode <= laser_cfg_pkg::RESET_REG;
         biasCurrentCode <= laser_cfg_pkg::RESET_REG;
         equalizerAdjustCode <= laser_cfg_pkg::RESET_REG;
      end else if (wrEn) begin
         case (wrAddr)
            laser_cfg_pkg::ADDR_CONTROL_FLAGS: begin
               controlFlags <= wrData & laser_cfg_pkg::CONTROL_WRITE_MASK;
            end
            laser_cfg_pkg::ADDR_MODULATION_CODE: begin
               modulationCurrentCode <= wrData;
            end
            laser_cfg_pkg::ADDR_BIAS_CODE: begin
               biasCurrentCode <= wrData;
            end
            laser_cfg_pkg::ADDR_EQUALIZER_CODE: begin
               equalizerAdjustCode <= wrData;
            end
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------

   a_reset_zero: assert property (@(posedge clk_sys)
      !rst_n |=> (controlFlags == 8'h00) && (modulationCurrentCode == 8'h00)
         && (biasCurrentCode == 8'h00) && (equalizerAdjustCode == 8'h00))
      else $error("registers not cleared by reset");

   a_unused_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wrEn && (wrAddr > 3'h3) |=> $stable(controlFlags) && $stable(modulationCurrentCode)
         && $stable(biasCurrentCode) && $stable(equalizerAdjustCode))
      else $error("write to unused address changed a register");

endmodule

// ### verification/serial_master_model.sv
module serial_master_model (
   input wire logic clk_sys,
   output logic sda,
   output logic sck
);
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------
   // idle lines
   // ----------------------------------------
   // both lines rest high between frames, as the pull-ups leave them
   initial begin
      sda = 1'b1;
      sck = 1'b1;
   end

   // one half period of the link clock, counted in falling edges of the system clock
   task automatic wait_half(input int halfCycles);
      repeat (halfCycles) @(negedge clk_sys);
   endtask

   // ----------------------------------------
   // frame driver
   // ----------------------------------------
   // start, address then data msb first, stop; nBits other than 11 makes a bad frame
   task automatic send_frame(input logic [10:0] frame, input int nBits, input int halfCycles);
      int i;
      @(negedge clk_sys);
      sda = 1'b0;
      wait_half(halfCycles);
      sck = 1'b0;
      repeat (2) @(negedge clk_sys);
      for (i = 0; i < nBits; i++) begin
         sda = (i < 11) ? frame[10 - i] : 1'b0;
         wait_half(halfCycles - 2);
         sck = 1'b1;
         wait_half(halfCycles);
         sck = 1'b0;
         repeat (2) @(negedge clk_sys);
      end
      // stop: sda rises while sck is high
      sda = 1'b0;
      wait_half(halfCycles - 2);
      sck = 1'b1;
      wait_half(halfCycles);
      sda = 1'b1;
      wait_half(halfCycles);
   endtask
endmodule

// ### verification/laser_driver_control_registers_test.sv
module laser_driver_control_registers_test;
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------
   // signals and bookkeeping
   // ----------------------------------------
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic sda, sck, faultClear;
   logic chipEnableBit, photodiodePolarityBit, photodiodeRangeBit, openLoopSelectBit;
   logic faultDetectEnableBit, modulationRangeBit, equalizerBypassBit;
   logic [7:0] modulationCurrentCode, biasCurrentCode, equalizerAdjustCode, equalizerStrength;
   logic [15:0] modCurrentUa;
   logic [4:0] pdStepTenthUa;
   logic [31:0] regsNow, derivedNow, expRegs = 32'h0000_0000;
   logic [31:0] notes[$];
   int badCount = 0;
   int nChecks = 0;
   int seed = 32'h0000_16A5;
   int i;

   always #20 clk_sys = ~clk_sys;

   serial_master_model i_serial_master_model (.clk_sys(clk_sys), .sda(sda), .sck(sck));

   laser_driver_control_registers i_laser_driver_control_registers (
      .clk_sys(clk_sys), .rst_n(rst_n), .sda(sda), .sck(sck),
      .chipEnableBit(chipEnableBit), .photodiodePolarityBit(photodiodePolarityBit),
      .photodiodeRangeBit(photodiodeRangeBit), .openLoopSelectBit(openLoopSelectBit),
      .faultDetectEnableBit(faultDetectEnableBit), .modulationRangeBit(modulationRangeBit),
      .equalizerBypassBit(equalizerBypassBit), .modulationCurrentCode(modulationCurrentCode),
      .biasCurrentCode(biasCurrentCode), .equalizerAdjustCode(equalizerAdjustCode),
      .faultClear(faultClear), .modCurrentUa(modCurrentUa), .pdStepTenthUa(pdStepTenthUa),
      .equalizerStrength(equalizerStrength)
   );

   // register outputs packed as control, modulation, bias, equalizer
   assign regsNow = {chipEnableBit, photodiodePolarityBit, photodiodeRangeBit,
      openLoopSelectBit, faultDetectEnableBit, modulationRangeBit, equalizerBypassBit,
      1'b0, modulationCurrentCode, biasCurrentCode, equalizerAdjustCode};
   assign derivedNow = {modCurrentUa, 3'b000, pdStepTenthUa, equalizerStrength};

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] want);
      nChecks++;
      if (got !== want) begin
         badCount++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, want);
      end
   endtask

   // derived outputs expected from a register image
   function automatic logic [31:0] derived(input logic [31:0] r);
      logic [15:0] ua;
      logic [4:0] pd;
      logic [7:0] eq;
      ua = {8'h00, r[23:16]} * (r[26] ? 16'h009C : 16'h004E);
      pd = r[29] ? 5'h19 : 5'h05;
      eq = r[25] ? 8'h00 : ~r[7:0];
      return {ua, 3'b000, pd, eq};
   endfunction

   task automatic end_test(input string name);
      $display("test %s finished, checks so far %0d", name, nChecks);
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", nChecks, badCount);
      if (badCount == 0 && nChecks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // one serial write; a change is noted for the watcher, no change is checked here
   task automatic write_reg(input logic [2:0] addr, input logic [7:0] data,
      input int nBits = 11, input int half = 4);
      logic [31:0] next;
      next = expRegs;
      if (nBits == 11) begin
         case (addr)
            3'h0: next[31:24] = data & 8'hFE;
            3'h1: next[23:16] = data;
            3'h2: next[15:8] = data;
            3'h3: next[7:0] = data;
            default: ;
         endcase
      end
      if (next !== expRegs) notes.push_back(next);
      i_serial_master_model.send_frame({addr, data}, nBits, half);
      repeat (6) @(negedge clk_sys);
      if (next === expRegs) check(regsNow, expRegs);
      expRegs = next;
   endtask

   // ----------------------------------------
   // watchers
   // ----------------------------------------
   // oldest note against outputs after each change
   initial begin
      logic [31:0] want;
      wait (rst_n === 1'b1);
      forever begin
         @(regsNow);
         repeat (2) @(negedge clk_sys);
         want = (notes.size() > 0) ? notes.pop_front() : ~regsNow;
         check(regsNow, want);
         if (rst_n === 1'b1) check(derivedNow, derived(want));
      end
   end

   // fault clear pulse lands one cycle after each enable rise
   always @(posedge chipEnableBit) begin
      if (rst_n === 1'b1) begin
         @(negedge clk_sys);
         check({31'h0000_0000, faultClear}, 32'h0000_0000);
         @(negedge clk_sys);
         check({31'h0000_0000, faultClear}, 32'h0000_0001);
      end
   end

   // hang guard well beyond the expected run
   initial begin
      repeat (30000) @(posedge clk_sys);
      badCount++;
      finish_test();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (8) @(negedge clk_sys);
      check(regsNow, 32'h0000_0000);
      check({derivedNow[31:1], faultClear}, 32'h0000_0500);
      rst_n = 1'b1;
      repeat (4) @(negedge clk_sys);
      end_test("reset");
      write_reg(3'h2, 8'hA5);
      write_reg(3'h1, 8'hFF);
      write_reg(3'h0, 8'h84);
      write_reg(3'h0, 8'h80);
      write_reg(3'h3, 8'h00);
      write_reg(3'h3, 8'hFF);
      write_reg(3'h0, 8'h82);
      end_test("boundaries");
      for (i = 0; i < 24; i++) begin
         write_reg(3'($random(seed)), 8'($random(seed)));
      end
      end_test("random");
      write_reg(3'h0, expRegs[31:24] | 8'h01);
      for (i = 4; i < 8; i++) begin
         write_reg(3'(i), 8'($random(seed)));
      end
      write_reg(3'h1, ~expRegs[23:16], 10);
      write_reg(3'h1, ~expRegs[23:16], 12);
      write_reg(3'h2, ~expRegs[15:8], 11, 8);
      end_test("refused and slow");
      write_reg(3'h0, 8'h08);
      write_reg(3'h0, 8'h88);
      notes.push_back(32'h0000_0000);
      rst_n = 1'b0;
      repeat (8) @(negedge clk_sys);
      rst_n = 1'b1;
      expRegs = 32'h0000_0000;
      repeat (4) @(negedge clk_sys);
      write_reg(3'h0, 8'hFF);
      check(notes.size(), 32'h0000_0000);
      end_test("enable toggle and second reset");
      finish_test();
   end
endmodule
